/* File: test_usb_ep_mask_close.sv */
// self-checking bench for the endpoint mask and close block
`timescale 1ns/1ps
`default_nettype none
module test_usb_ep_mask_close import usb_ep_pkg::*; ;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        close_strap = 1'b1;
	logic        ce = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] ep_event = 32'h0;
	logic [3:0]  delay = 4'h0;
	logic        pready, pslverr, irq, req, closed, wbv, wbl, er;
	logic [31:0] prdata, rd;
	logic [3:0]  cep;
	logic [15:0] acc, wbb;
	int          n_mismatch = 0;
	int          check_count = 0;
	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic        er;
	} row_t;
	row_t rows[6] = '{'{MASK_OFF, 32'hffff_0000, 32'hffff_0000, 1'b0},
		'{MASK_OFF, 32'h0000_ffff, 32'h0000_ffff, 1'b0},
		'{CFG_OFF, 32'h3, 32'h3, 1'b0}, '{12'h044, 32'h800, 32'h0, 1'b0},
		'{12'h00c, 32'h1, 32'h0, 1'b1}, '{12'h006, 32'h1, 32'h0, 1'b1}};
	int          md[4] = '{0, 3, 1, 2};
	int          dl[4] = '{10, 0, 12, 3};
	logic [3:0]  en[4] = '{4'h0, 4'h7, 4'hf, 4'h9};
	always #20 pclk = ~pclk;
	////////////////////////////////////////
	usb_ep_mask_close u_dut (.pclk, .presetn, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .close_strap,
		.ep_event, .chan_close_req(req), .chan_close_ep(cep),
		.chan_closed(closed), .chan_acc_bytes(acc), .desc_wb_valid(wbv),
		.desc_wb_last(wbl), .desc_wb_rx_bytes(wbb), .irq);
	usb_ep_desc_model u_eng (.pclk, .presetn, .req, .ep(cep), .delay,
		.closed, .acc_bytes(acc));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	// setup then access; hold all until pready seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_wb;
		int k = 0;
		do @(posedge pclk); while (wbv !== 1'b1 && ++k < 50);
	endtask
	task automatic close_ep(input logic [3:0] n, input logic [15:0] b);
		logic [11:0] a;
		a = 12'h080 + {n, 2'b00}; // out endpoint words only
		apb(1'b1, a, 32'h800);
		if (delay != 4'h0) begin
			apb(1'b0, a, 32'h0);
			chk(rd, 32'h800);
		end
		wait_wb;
		chk(wbl, 1'b1);
		chk(wbb, b);
		apb(1'b0, a, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h1 << (16 + n));
		chk(irq, 1'b1);
		apb(1'b1, STATUS_OFF, rd);
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////
	// watchdog: far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MASK_OFF, 32'h0);
		chk(rd, MASK_RESET);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
			chk(er, rows[i].er);
		end
		// masked events neither set status nor raise irq
		apb(1'b1, MASK_OFF, 32'h0001_0001);
		@(posedge pclk) ep_event <= 32'h0003_0003;
		@(posedge pclk) ep_event <= 32'h0;
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h0002_0002);
		apb(1'b1, STATUS_OFF, 32'h0000_0002);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h0002_0000);
		chk(irq, 1'b1);
		// enable low freezes state: an event in that cycle is lost
		@(posedge pclk) begin
			ce       <= 1'b0;
			ep_event <= 32'h0000_0100;
		end
		@(posedge pclk) ep_event <= 32'h0;
		@(posedge pclk) ce <= 1'b1;
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h0002_0000);
		apb(1'b1, MASK_OFF, 32'hffff_ffff);
		apb(1'b1, STATUS_OFF, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, STATUS_OFF, 32'h0002_0000);
		apb(1'b1, MASK_OFF, 32'h0);
		// every buffer mode, prompt and slow engine
		foreach (md[i]) begin
			delay <= dl[i][3:0];
			apb(1'b1, CFG_OFF, md[i]);
			close_ep(en[i], md[i] == 3 ? 16'h0 : {12'h5a0, en[i]});
		end
		// second close queued while first is busy
		apb(1'b1, 12'h088, 32'h800);
		apb(1'b1, 12'h08c, 32'h800);
		for (int i = 2; i < 4; i++) begin
			wait_wb;
			chk(wbb, {12'h5a0, i[3:0]});
		end
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h000c_0000);
		// strap low in a second reset: close bit inert
		presetn     <= 1'b0;
		close_strap <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h084, 32'h800);
		apb(1'b0, 12'h084, 32'h0);
		chk(rd, 32'h0);
		repeat (20) @(posedge pclk);
		finish_test;
	end
endmodule // test_usb_ep_mask_close
`default_nettype wire

/* File: usb_ep_close_seq.sv */
// sequencer that closes one out endpoint descriptor channel at a time
`timescale 1ns/1ps
`default_nettype none
module usb_ep_close_seq import usb_ep_pkg::*; (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	// requests and mode
	input  wire logic [NUM_EP-1:0]     pend,
	input  wire logic                  ppb_mode,
	input  wire logic                  desc_upd,
	// descriptor engine
	output logic                       req,
	output logic [3:0]                 req_ep,
	input  wire logic                  closed,
	input  wire logic [BYTE_CNT_W-1:0] acc_bytes,
	output logic                       wb_valid,
	output logic                       wb_last,
	output logic [BYTE_CNT_W-1:0]      wb_bytes,
	// one-hot completion pulse
	output logic [NUM_EP-1:0]          done
);

	typedef struct packed {
		close_state_t            st;
		logic                    req;
		logic [3:0]              ep;
		logic                    wb_valid;
		logic                    wb_last;
		logic [BYTE_CNT_W-1:0]   wb_bytes;
		logic [NUM_EP-1:0]       done;
	} seq_state_t;

	seq_state_t s_q;
	seq_state_t s_d;

	// lowest pending endpoint is served first
	always_comb begin
		logic       found;
		logic [3:0] pick;
		found = 1'b0;
		pick  = 4'h0;
		for (int i = 0; i < NUM_EP; i++) begin
			if (pend[i] && !found) begin
				found = 1'b1;
				pick  = 4'(i);
			end
		end
		s_d          = s_q;
		s_d.wb_valid = 1'b0;
		s_d.done     = '0;
		unique case (s_q.st)
			CS_IDLE: begin
				if (found) begin
					s_d.st  = CS_WAIT;
					s_d.req = 1'b1;
					s_d.ep  = pick;
				end
			end
			CS_WAIT: begin
				if (closed) begin
					s_d.st       = CS_DONE;
					s_d.req      = 1'b0;
					s_d.wb_valid = 1'b1;
					s_d.wb_last  = 1'b1;
					// fill mode keeps count ppb+update zero
					if (ppb_mode && desc_upd) begin
						s_d.wb_bytes = '0;
					end else begin
						s_d.wb_bytes = acc_bytes;
					end
					s_d.done[s_q.ep] = 1'b1;
				end
			end
			CS_DONE: begin
				// one idle cycle lets the close bit fall first
				s_d.st = CS_IDLE;
			end
			default: begin
				s_d.st  = CS_IDLE;
				s_d.req = 1'b0;
			end
		endcase
	end

	// registered copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{st: CS_IDLE, ep: 4'h0, wb_bytes: '0, done: '0,
				default: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign req      = s_q.req;
	assign req_ep   = s_q.ep;
	assign wb_valid = s_q.wb_valid;
	assign wb_last  = s_q.wb_last;
	assign wb_bytes = s_q.wb_bytes;
	assign done     = s_q.done;

endmodule // usb_ep_close_seq
`default_nettype wire

/* File: usb_ep_desc_model.sv */
// descriptor engine model answering channel close requests
`timescale 1ns/1ps
`default_nettype none
module usb_ep_desc_model (
	// clock and reset
	input wire logic    pclk,
	input wire logic    presetn,
	// close handshake
	input wire logic       req,
	input wire logic [3:0] ep,
	input wire logic [3:0] delay,
	output logic           closed,
	output logic [15:0]    acc_bytes
);
	logic [3:0] cnt_q;
	wire logic  fire = req && !closed && cnt_q == delay;
	// wait, then pulse closed; count is garbage outside the pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q     <= 4'h0;
			closed    <= 1'b0;
			acc_bytes <= 16'h0000;
		end else begin
			cnt_q     <= (req && !fire) ? cnt_q + 4'h1 : 4'h0;
			closed    <= fire;
			acc_bytes <= fire ? {12'h5a0, ep} : ~acc_bytes;
		end
	end
endmodule // usb_ep_desc_model
`default_nettype wire

/* File: usb_ep_irq.sv */
// endpoint interrupt status, mask and the single interrupt line
`timescale 1ns/1ps
`default_nettype none
module usb_ep_irq import usb_ep_pkg::*; #(
	parameter logic [31:0] MASK_INIT = MASK_RESET
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// events, out endpoints high half
	input  wire logic [31:0] ev,
	// software writes
	input  wire logic        mask_wr,
	input  wire logic        stat_wr,
	input  wire logic [31:0] wdata,
	// state
	output logic      [31:0] status,
	output logic      [31:0] mask,
	output logic             irq
);

	typedef struct packed {
		logic [31:0] status;
		logic [31:0] mask;
		logic        irq;
	} irq_state_t;

	irq_state_t s_q;
	irq_state_t s_d;

	// masked sources never reach status set beats clear
	always_comb begin
		s_d = s_q;
		if (mask_wr) begin
			s_d.mask = wdata;
		end
		if (stat_wr) begin
			s_d.status = s_q.status & ~wdata;
		end
		s_d.status = s_d.status | (ev & ~s_q.mask);
		s_d.irq    = |(s_d.status & ~s_d.mask);
	end

	// registered copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{status: 32'h0000_0000, mask: MASK_INIT, irq: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign status = s_q.status;
	assign mask   = s_q.mask;
	assign irq    = s_q.irq;

endmodule // usb_ep_irq
`default_nettype wire

/* File: usb_ep_mask_close.sv */
// apb register block: endpoint masks, status and descriptor close
`timescale 1ns/1ps
`default_nettype none
module usb_ep_mask_close import usb_ep_pkg::*; #(
	parameter logic [31:0] MASK_INIT = MASK_RESET
) (
	// clock, enable and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// static strap for the close capability
	input  wire logic                  close_strap,
	// endpoint events from the protocol logic
	input  wire logic [31:0]           ep_event,
	// descriptor engine close handshake
	output logic                       chan_close_req,
	output logic [3:0]                 chan_close_ep,
	input  wire logic                  chan_closed,
	input  wire logic [BYTE_CNT_W-1:0] chan_acc_bytes,
	// descriptor write-back
	output logic                       desc_wb_valid,
	output logic                       desc_wb_last,
	output logic [BYTE_CNT_W-1:0]      desc_wb_rx_bytes,
	// interrupt
	output logic                       irq
);

	////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [NUM_EP-1:0] close;   // out endpoint close requests
		logic [1:0]        cfg;     // buffer mode bits
		logic              strap_ok;
		logic              strap_seen;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	logic [31:0]       status;
	logic [31:0]       mask;
	logic [NUM_EP-1:0] done;
	logic [31:0]       irq_ev;

	////////////////////////////////////////////////////////////////
	// address decode, held stable through setup and access

	logic       hi_zero;
	logic       hit_status;
	logic       hit_mask;
	logic       hit_cfg;
	logic       hit_in;
	logic       hit_out;
	logic       hit_any;
	logic [3:0] ep_idx;
	logic       wr_ok;

	// two control pages, one word per endpoint and direction
	assign hi_zero    = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
	assign hit_status = hi_zero && (paddr[7:0] == STATUS_OFF);
	assign hit_mask   = hi_zero && (paddr[7:0] == MASK_OFF);
	assign hit_cfg    = hi_zero && (paddr[7:0] == CFG_OFF);
	assign hit_in     = hi_zero && (paddr[7:6] == IN_CTRL_PAGE);
	assign hit_out    = hi_zero && (paddr[7:6] == OUT_CTRL_PAGE);
	assign hit_any    = hit_status | hit_mask | hit_cfg | hit_in
		| hit_out;
	assign ep_idx     = paddr[5:2];

	// a write lands only on the completing edge of a good access
	assign wr_ok = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;

	////////////////////////////////////////////////////////////////
	// interrupt status and mask

	// finished closes flag their out endpoint
	assign irq_ev = ep_event | {done, 16'h0000};

	usb_ep_irq #(
		.MASK_INIT (MASK_INIT)
	) u_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.ev      (irq_ev),
		.mask_wr (wr_ok & hit_mask),
		.stat_wr (wr_ok & hit_status),
		.wdata   (pwdata),
		.status  (status),
		.mask    (mask),
		.irq     (irq)
	);

	////////////////////////////////////////////////////////////////
	// close sequencer

	logic [NUM_EP-1:0] pend;

	// with the strap off no request ever leaves the block
	assign pend = s_q.strap_ok ? s_q.close : '0;

	usb_ep_close_seq u_seq (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.pend      (pend),
		.ppb_mode  (s_q.cfg[CFG_PPB_BIT]),
		.desc_upd  (s_q.cfg[CFG_DUPD_BIT]),
		.req       (chan_close_req),
		.req_ep    (chan_close_ep),
		.closed    (chan_closed),
		.acc_bytes (chan_acc_bytes),
		.wb_valid  (desc_wb_valid),
		.wb_last   (desc_wb_last),
		.wb_bytes  (desc_wb_rx_bytes),
		.done      (done)
	);

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;

		// strap is sampled once, first enabled cycle after reset
		if (!s_q.strap_seen) begin
			s_d.strap_seen = 1'b1;
			s_d.strap_ok   = close_strap;
		end

		// setup phase: decode and fetch, answer in the access phase
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		if (psel && !penable) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = ~hit_any;
			s_d.prdata  = 32'h0000_0000;
			if (hit_status) begin
				s_d.prdata = status;
			end
			if (hit_mask) begin
				s_d.prdata = mask;
			end
			if (hit_cfg) begin
				s_d.prdata[CFG_PPB_BIT]  = s_q.cfg[CFG_PPB_BIT];
				s_d.prdata[CFG_DUPD_BIT] = s_q.cfg[CFG_DUPD_BIT];
			end
			// in endpoint words hold no close bit
			if (hit_out) begin
				s_d.prdata[CLOSE_BIT] = s_q.close[ep_idx];
			end
		end else if (psel && penable && s_q.pready) begin
			s_d.pready = 1'b0;
		end

		// hardware clears the request once the channel is closed
		s_d.close = s_q.close & ~done;

		// a software write after it wins for the same endpoint
		if (wr_ok && hit_out && s_q.strap_ok) begin
			s_d.close[ep_idx] = pwdata[CLOSE_BIT];
		end

		// mode bits steer the byte count on write-back
		if (wr_ok && hit_cfg) begin
			s_d.cfg[CFG_PPB_BIT]  = pwdata[CFG_PPB_BIT];
			s_d.cfg[CFG_DUPD_BIT] = pwdata[CFG_DUPD_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// registered copy

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{close: CLOSE_RESET, cfg: CFG_RESET,
				prdata: 32'h0000_0000, default: 1'b0};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops

	assign pready  = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign prdata  = s_q.prdata;

endmodule // usb_ep_mask_close
`default_nettype wire

/* File: usb_ep_mask_close_monitor.sv */
// port assertions for the endpoint mask and close block
`timescale 1ns/1ps
`default_nettype none
module usb_ep_mask_close_monitor (
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       ce,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic       pready,
	input wire logic       pslverr,
	// close handshake and interrupt
	input wire logic       close_strap,
	input wire logic       chan_close_req,
	input wire logic [3:0] chan_close_ep,
	input wire logic       chan_closed,
	input wire logic       desc_wb_valid,
	input wire logic       desc_wb_last,
	input wire logic       irq
);
	// a finished write: the only thing that may drop irq
	wire logic wr_done = psel && penable && pwrite && pready;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// apb answer
	property p_answer; psel && !penable && ce |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no apb answer");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready too long");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray pslverr");
	////////////////////////////////////////
	// close handshake and write-back
	property p_hold;
		chan_close_req && !chan_closed |=>
			chan_close_req && $stable(chan_close_ep);
	endproperty
	a_hold: assert property (p_hold) else $error("req dropped");
	property p_wb;
		chan_close_req && chan_closed |=> desc_wb_valid && !chan_close_req;
	endproperty
	a_wb: assert property (p_wb) else $error("no write-back");
	property p_last; desc_wb_valid |-> desc_wb_last; endproperty
	a_last: assert property (p_last) else $error("last missing");
	property p_gap; desc_wb_valid |=> !desc_wb_valid && !chan_close_req;
	endproperty
	a_gap: assert property (p_gap) else $error("wb not single");
	property p_strap; !close_strap |-> !chan_close_req; endproperty
	a_strap: assert property (p_strap) else $error("close w/o strap");
	// status is sticky, so irq only falls after a write
	property p_irq; $fell(irq) |-> $past(wr_done) || $past(wr_done, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq fell alone");
	c_close: cover property (chan_close_req && chan_closed);
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
endmodule // usb_ep_mask_close_monitor
bind usb_ep_mask_close usb_ep_mask_close_monitor u_mon (.pclk, .presetn,
	.ce, .psel, .penable, .pwrite, .pready, .pslverr, .close_strap,
	.chan_close_req, .chan_close_ep, .chan_closed, .desc_wb_valid,
	.desc_wb_last, .irq);
`default_nettype wire

/* File: usb_ep_pkg.sv */
// constants and types shared by the endpoint mask and close logic
package usb_ep_pkg;

	// endpoint count per direction
	localparam int NUM_EP = 16;
	localparam int BYTE_CNT_W = 16;

	// register byte offsets on the apb slave
	localparam logic [7:0] STATUS_OFF    = 8'h00;
	localparam logic [7:0] MASK_OFF      = 8'h04;
	localparam logic [7:0] CFG_OFF       = 8'h08;
	localparam logic [1:0] IN_CTRL_PAGE  = 2'h1; // 0x40..0x7c
	localparam logic [1:0] OUT_CTRL_PAGE = 2'h2; // 0x80..0xbc

	// field positions
	localparam int CLOSE_BIT    = 11;
	localparam int CFG_PPB_BIT  = 0; // packet-per-buffer mode
	localparam int CFG_DUPD_BIT = 1; // descriptor update enable
	localparam int OUT_LSB      = 16;

	// values after reset
	localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
	localparam logic [1:0]  CFG_RESET   = 2'h0;
	localparam logic [15:0] CLOSE_RESET = 16'h0000;

	// close sequencer states
	typedef enum logic [1:0] {
		CS_IDLE = 2'b00,
		CS_WAIT = 2'b01,
		CS_DONE = 2'b10
	} close_state_t;

endpackage
